// ==== bench/ltic_framer_model.sv ====
// Framer side model: gated link clocks and transmit rails
`timescale 1ns/1ps
`default_nettype none

module ltic_framer_model (
  // Bench control
  input wire logic [7:0] run_in,
  input wire logic [7:0] pos_want_in,
  input wire logic [7:0] neg_want_in,
  // Far side signals
  output logic [7:0] link_clk_out,
  output logic [7:0] pos_out,
  output logic [7:0] neg_out
);
  logic lclk;
  logic [7:0] run_r;

  initial begin
    lclk = 1'b0;
    forever #24 lclk = ~lclk;
  end

  // Gate changes only while low so a stopped clock rests low
  always @(negedge lclk) run_r <= run_in;
  assign link_clk_out = run_r & {8{lclk}};

  // Rails move after the rising edge; idle channels fall to the pulled low level
  always @(posedge lclk) begin
    pos_out <= run_r & pos_want_in;
    neg_out <= run_r & neg_want_in;
  end
endmodule // ltic_framer_model

`default_nettype wire

// ==== bench/ltic_tx_input_ctrl_assertions.sv ====
// Port checker for the transmit input control block
`timescale 1ns/1ps
`default_nettype none

module ltic_tx_input_ctrl_checker (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Link clocks and pins
  input wire logic [7:0] tx_line_clock,
  input wire logic select_a_in,
  input wire logic tx_sample_edge_sel_in,
  input wire logic host_bus_type_lo_in,
  input wire logic [7:0] tx_output_enable_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // Line outputs
  input wire logic [7:0] tx_line_pos_out,
  input wire logic [7:0] tx_line_neg_out,
  input wire logic [7:0] tx_line_oe_out,
  input wire logic [1:0] host_bus_type_sel_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [7:0] seen_r;
  logic [6:0] quiet_r [8];
  logic [7:0] stuck;

  // ***************************************************************
  // Link clock quiet time per channel
  // ***************************************************************
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      seen_r <= 8'h00;
      for (int i = 0; i < 8; i++) quiet_r[i] <= 7'h00;
    end else begin
      seen_r <= tx_line_clock;
      for (int i = 0; i < 8; i++) begin
        if (tx_line_clock[i] != seen_r[i]) quiet_r[i] <= 7'h00;
        else if (quiet_r[i] != 7'h64) quiet_r[i] <= quiet_r[i] + 7'h01;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 8; i++) stuck[i] = (quiet_r[i] == 7'h64);
  end

  // ***************************************************************
  // Properties
  // ***************************************************************
  sequence s_write;
    reg_wr_in && reg_addr_in <= 4'h8;
  endsequence
  sequence s_read_back;
    reg_rd_in && reg_addr_in == $past(reg_addr_in, 2);
  endsequence
  sequence s_rst_done;
    $fell(sys_rst_in);
  endsequence
  property p_write_read;
    s_write ##1 !reg_wr_in ##1 s_read_back |=> reg_rdata_out == ($past(reg_wdata_in, 3) &
      ($past(reg_addr_in, 3) == 4'h8 ? ltic_pkg::GLOBAL_MASK : ltic_pkg::CH_REG_MASK));
  endproperty
  property p_read_idle;
    !reg_rd_in |=> reg_rdata_out == 8'h00;
  endproperty
  property p_unmapped;
    reg_rd_in && reg_addr_in > 4'hb |=> reg_rdata_out == 8'h00;
  endproperty
  property p_oe_gate;
    ((tx_line_pos_out | tx_line_neg_out) & ~tx_line_oe_out) == 8'h00;
  endproperty
  property p_loss_zero;
    ((tx_line_pos_out | tx_line_neg_out) & stuck) == 8'h00;
  endproperty
  property p_rst_off;
    s_rst_done |-> {tx_line_pos_out, tx_line_neg_out, tx_line_oe_out} == 24'h000000 ##1 tx_line_oe_out == 8'h00;
  endproperty
  property p_hw_oe;
    (select_a_in && $stable(tx_output_enable_in)) [*5] |-> tx_line_oe_out == tx_output_enable_in;
  endproperty
  property p_bus_type;
    ($stable(select_a_in) && $stable(tx_sample_edge_sel_in) && $stable(host_bus_type_lo_in)) [*5] |->
      host_bus_type_sel_out == (select_a_in ? 2'h0 : {tx_sample_edge_sel_in, host_bus_type_lo_in});
  endproperty

  a_write_read: assert property (p_write_read) else $error("read back differs from write");
  a_read_idle: assert property (p_read_idle) else $error("read data outside read slot");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_oe_gate: assert property (p_oe_gate) else $error("pulse on disabled channel");
  a_loss_zero: assert property (p_loss_zero) else $error("pulse without link clock");
  a_rst_off: assert property (p_rst_off) else $error("outputs active after reset");
  a_hw_oe: assert property (p_hw_oe) else $error("enable pins not followed");
  a_bus_type: assert property (p_bus_type) else $error("bus type output wrong");
endmodule // ltic_tx_input_ctrl_checker

bind ltic_tx_input_ctrl ltic_tx_input_ctrl_checker u_checker (.ref_clk_in, .sys_rst_in, .tx_line_clock, .select_a_in,
  .tx_sample_edge_sel_in, .host_bus_type_lo_in, .tx_output_enable_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
  .reg_rd_in, .reg_rdata_out, .tx_line_pos_out, .tx_line_neg_out, .tx_line_oe_out, .host_bus_type_sel_out);

`default_nettype wire

// ==== bench/tb.sv ====
// Testbench for the transmit input control block
`timescale 1ns/1ps
`default_nettype none
`define chk(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected t=%0t got %h want %h", $time, a, b); end end

module tb;
  logic ref_clk_in, sys_rst_in, select_a_in, tx_sample_edge_sel_in, host_bus_type_lo_in;
  logic hw_dual_rail_in, hw_rate_e1_in, reg_wr_in, reg_rd_in;
  logic [3:0] reg_addr_in;
  logic [7:0] tx_all_ones_req_in, tx_output_enable_in, reg_wdata_in, run, pos_want, neg_want, acc_p, acc_n;
  wire [7:0] tx_line_clock, tx_pos_rail_in, tx_neg_rail_in, reg_rdata_out, tx_line_pos_out, tx_line_neg_out;
  wire [7:0] tx_line_oe_out;
  wire [1:0] host_bus_type_sel_out;
  int fail_count, num_checks, cycles;

  ltic_tx_input_ctrl u_ltic_tx_input_ctrl (.ref_clk_in, .sys_rst_in, .tx_line_clock, .tx_pos_rail_in,
    .tx_neg_rail_in, .select_a_in, .tx_sample_edge_sel_in, .host_bus_type_lo_in, .hw_dual_rail_in,
    .hw_rate_e1_in, .tx_all_ones_req_in, .tx_output_enable_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .tx_line_pos_out, .tx_line_neg_out, .tx_line_oe_out, .host_bus_type_sel_out);

  ltic_framer_model u_ltic_framer_model (.run_in(run), .pos_want_in(pos_want), .neg_want_in(neg_want),
    .link_clk_out(tx_line_clock), .pos_out(tx_pos_rail_in), .neg_out(tx_neg_rail_in));

  // ***************************************************************
  // Clock, timeout and tasks
  // ***************************************************************
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    `chk(reg_rdata_out, e)
  endtask

  // Settles, then gathers which channels pulsed on each output
  task automatic watch(input int n);
    pause(40);
    acc_p = 8'h00;
    acc_n = 8'h00;
    repeat (n) begin
      pause(1);
      acc_p |= tx_line_pos_out;
      acc_n |= tx_line_neg_out;
    end
  endtask

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    {sys_rst_in, select_a_in, hw_dual_rail_in} = 3'h7;
    {tx_sample_edge_sel_in, host_bus_type_lo_in, hw_rate_e1_in, reg_wr_in, reg_rd_in} = 5'h00;
    {tx_all_ones_req_in, reg_wdata_in, reg_addr_in} = 20'h00000;
    {tx_output_enable_in, run, pos_want, neg_want} = 32'hffff0ff0;
    {fail_count, num_checks, cycles} = '0;
    repeat (4) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    pause(1);
    `chk(tx_line_oe_out, 8'h00)
    pause(40);
    `chk(tx_line_oe_out, 8'hff)
    `chk(tx_line_pos_out, 8'h0f)
    `chk(tx_line_neg_out, 8'hf0)
    @(posedge ref_clk_in);
    tx_sample_edge_sel_in <= 1'b1;
    pos_want <= 8'h3c;
    neg_want <= 8'hc3;
    pause(40);
    `chk(tx_line_pos_out, 8'h3c)
    `chk(tx_line_neg_out, 8'hc3)
    @(posedge ref_clk_in);
    run <= 8'hf0;
    pause(150);
    `chk(tx_line_pos_out, 8'h30)
    `chk(tx_line_neg_out, 8'hc0)
    @(posedge ref_clk_in);
    run <= 8'hff;
    tx_output_enable_in <= 8'h0f;
    pause(40);
    `chk(tx_line_oe_out, 8'h0f)
    `chk(tx_line_neg_out, 8'h03)
    @(posedge ref_clk_in);
    {tx_output_enable_in, pos_want, neg_want} <= 24'hff000f;
    {hw_dual_rail_in, tx_sample_edge_sel_in} <= 2'h0;
    watch(200);
    `chk(acc_p | acc_n, 8'hf0)
    @(posedge ref_clk_in);
    hw_rate_e1_in <= 1'b1;
    watch(200);
    `chk(acc_p | acc_n, 8'hf0)
    @(posedge ref_clk_in);
    tx_all_ones_req_in <= 8'hff;
    watch(200);
    `chk(acc_p & acc_n, 8'hff)
    @(posedge ref_clk_in);
    {tx_all_ones_req_in, neg_want} <= 16'h00ff;
    {select_a_in, tx_sample_edge_sel_in} <= 2'h1;
    pause(6);
    `chk(tx_line_oe_out, 8'h00)
    `chk(host_bus_type_sel_out, 2'h2)
    for (int a = 0; a < 9; a++) rdc(4'(a), 8'h00);
    wr(4'h0, 8'hff);
    wr(4'h1, 8'h01);
    wr(4'h9, 8'h00);
    wr(4'hc, 8'hff);
    rdc(4'h0, 8'h1f);
    rdc(4'h9, 8'hff);
    rdc(4'hc, 8'h00);
    rdc(4'hb, 8'h05);
    `chk(tx_line_oe_out, 8'h03)
    rdc(4'ha, 8'h03);
    watch(200);
    `chk(acc_p, 8'h03)
    `chk(acc_n, 8'h03)
    wr(4'h8, 8'hff);
    rdc(4'h8, 8'h01);
    pause(4);
    `chk(tx_line_oe_out, 8'hff)
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk_in);
      tx_sample_edge_sel_in <= 1'b0;
      host_bus_type_lo_in <= k[0];
      pause(6);
      `chk(host_bus_type_sel_out, 2'(k))
    end
    conclude();
  end
endmodule // tb

`default_nettype wire

// ==== hdl/ltic_link_capture.sv ====
// Per-channel capture of transmit rails on the link clock
`timescale 1ns/1ps
`default_nettype none

module ltic_link_capture (
  // Link clock and reset
  input wire logic tx_line_clock,
  input wire logic sys_rst_in,
  // Global edge select pin
  input wire logic edge_sel_in,
  // Transmit rails
  input wire logic pos_in,
  input wire logic neg_in,
  // Crossing to the reference domain
  output logic tgl_out,
  output ltic_pkg::ltic_rails_t rails_out
);

  // ***************************************************************
  // State
  // ***************************************************************
  logic es1_r, es2_r;
  logic tgl_r, tgl_nxt;
  ltic_pkg::ltic_rails_t fall_r;
  ltic_pkg::ltic_rails_t rails_r, rails_nxt;

  // ***************************************************************
  // Sampling
  // ***************************************************************
  always_comb begin
    rails_nxt = es2_r ? ltic_pkg::ltic_rails_t'{pos: pos_in, neg: neg_in} : fall_r;
    tgl_nxt = ~tgl_r;
  end

  always_ff @(negedge tx_line_clock or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fall_r <= '0;
    end else begin
      fall_r <= '{pos: pos_in, neg: neg_in};
    end
  end

  always_ff @(posedge tx_line_clock or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      es1_r <= 1'b0;
      es2_r <= 1'b0;
      tgl_r <= 1'b0;
      rails_r <= '0;
    end else begin
      es1_r <= edge_sel_in;
      es2_r <= es1_r;
      tgl_r <= tgl_nxt;
      rails_r <= rails_nxt;
    end
  end

  assign tgl_out = tgl_r;
  assign rails_out = rails_r;

endmodule // ltic_link_capture

`default_nettype wire

// ==== hdl/ltic_tx_input_ctrl.sv ====
// Eight-channel transmit input control: sampling, line coding, all ones, output gating
// How it works
// - In hardware mode data is taken on the falling transmit clock edge, or the rising one when edge select is high.
// - In host mode the edge select pin is the upper bit of the host bus type code, 00 and 01 being the two bus styles.
// - In dual rail the partner drives positive and negative pulses on the two rails and both are taken every period.
// - In single rail only the positive rail carries NRZ data and host mode ignores the negative rail.
// - In hardware single rail the negative rail picks the code: low gives HDB3 or B8ZS, high gives AMI.
// - A channel whose transmit clock is missing or stuck sends all zeros.
// - The edge select is one global setting shared by all eight channels.
// - In hardware mode a high all-ones pin sends continuous ones, a low one passes data.
// - In host mode the all-ones request comes from a channel register bit.
// - After reset all transmitters are off until software or the enable pins turn them on.
// - Host mode with pin control low enables from software, otherwise the enable pins decide.
// - Mode select high means hardware mode and low means host mode with register control.
`timescale 1ns/1ps
`default_nettype none

module ltic_tx_input_ctrl (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Link clocks and rails
  input wire logic [7:0] tx_line_clock,
  input wire logic [7:0] tx_pos_rail_in,
  input wire logic [7:0] tx_neg_rail_in,
  // Mode and control pins
  input wire logic select_a_in,
  input wire logic tx_sample_edge_sel_in,
  input wire logic host_bus_type_lo_in,
  input wire logic hw_dual_rail_in,
  input wire logic hw_rate_e1_in,
  input wire logic [7:0] tx_all_ones_req_in,
  input wire logic [7:0] tx_output_enable_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Line outputs
  output logic [7:0] tx_line_pos_out,
  output logic [7:0] tx_line_neg_out,
  output logic [7:0] tx_line_oe_out,
  output logic [1:0] host_bus_type_sel_out
);

  localparam int N = ltic_pkg::NUM_CH;

  // ***************************************************************
  // Functions
  // ***************************************************************
  // One bit into the substitution delay line
  function automatic ltic_pkg::ltic_step_t ltic_code_step(
    input logic [ltic_pkg::DLY_W-1:0] dly,
    input logic par,
    input logic bit_in,
    input ltic_pkg::ltic_code_t code
  );
    ltic_pkg::ltic_step_t st;
    st.sym = dly[ltic_pkg::DLY_W-1 -: ltic_pkg::SYM_W];
    st.dly = {dly[ltic_pkg::DLY_W-ltic_pkg::SYM_W-1:0], bit_in ? ltic_pkg::SYM_MARK : ltic_pkg::SYM_ZERO};
    st.par = par ^ bit_in;
    case (code)
      ltic_pkg::LTIC_CODE_B8ZS: begin
        if (st.dly == ltic_pkg::DLY_RST) begin
          st.dly = ltic_pkg::B8ZS_SUBST;
        end
      end
      ltic_pkg::LTIC_CODE_HDB3: begin
        if (st.dly[ltic_pkg::HDB3_W-1:0] == ltic_pkg::DLY_RST[ltic_pkg::HDB3_W-1:0]) begin
          st.dly[ltic_pkg::HDB3_W-1:0] = st.par ? ltic_pkg::HDB3_ODD : ltic_pkg::HDB3_EVEN;
          st.par = 1'b0;
        end
      end
      default: begin
        st.par = par ^ bit_in;
      end
    endcase
    return st;
  endfunction

  // Polarity of a symbol given the polarity of the last pulse
  function automatic logic ltic_sym_pol(
    input logic [ltic_pkg::SYM_W-1:0] sym,
    input logic last
  );
    return (sym == ltic_pkg::SYM_VIOL) ? last : ~last;
  endfunction

  // ***************************************************************
  // Link domain capture
  // ***************************************************************
  logic [N-1:0] link_tgl;
  ltic_pkg::ltic_rails_t [N-1:0] link_rails;

  for (genvar g = 0; g < N; g++) begin : g_link
    ltic_link_capture u_capture (
      .tx_line_clock(tx_line_clock[g]),
      .sys_rst_in(sys_rst_in),
      .edge_sel_in(tx_sample_edge_sel_in),
      .pos_in(tx_pos_rail_in[g]),
      .neg_in(tx_neg_rail_in[g]),
      .tgl_out(link_tgl[g]),
      .rails_out(link_rails[g])
    );
  end

  // ***************************************************************
  // State
  // ***************************************************************
  ltic_pkg::ltic_pins_t pin_raw;
  ltic_pkg::ltic_pins_t pin_s1_r, pin_s2_r;
  logic [N-1:0] tgl_s1_r, tgl_s2_r, tgl_s3_r;
  ltic_pkg::ltic_rails_t [N-1:0] rx_r, rx_nxt;
  logic [N-1:0][ltic_pkg::LOSS_W-1:0] loss_r, loss_nxt;
  logic [N-1:0][ltic_pkg::DLY_W-1:0] dly_r, dly_nxt;
  logic [N-1:0] par_r, par_nxt;
  logic [N-1:0] last_r, last_nxt;
  logic [N-1:0][ltic_pkg::DATA_W-1:0] ch_reg_r, ch_reg_nxt;
  logic [ltic_pkg::DATA_W-1:0] global_r, global_nxt;
  logic [ltic_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
  logic [N-1:0] pos_r, pos_nxt;
  logic [N-1:0] neg_r, neg_nxt;
  logic [N-1:0] oe_r, oe_nxt;
  logic [1:0] bus_type_r, bus_type_nxt;

  // ***************************************************************
  // Derived controls
  // ***************************************************************
  logic [N-1:0] strobe;
  logic [N-1:0] clk_ok;
  logic [N-1:0] oe_eff;
  logic [N-1:0] aos_eff;
  logic host_mode;
  logic pin_ctl;
  ltic_pkg::ltic_code_t code_sel [N];
  logic [N-1:0] dual_sel;

  assign pin_raw = '{edge_sel: tx_sample_edge_sel_in, mode_hw: select_a_in, bus_lo: host_bus_type_lo_in,
                     dual_rail: hw_dual_rail_in, rate_e1: hw_rate_e1_in,
                     all_ones: tx_all_ones_req_in, tx_on: tx_output_enable_in};
  assign strobe = tgl_s2_r ^ tgl_s3_r;
  assign host_mode = ~pin_s2_r.mode_hw;
  assign pin_ctl = global_r[ltic_pkg::GL_PIN_CTL_BIT];

  always_comb begin
    logic ami;
    logic e1;
    ami = 1'b0;
    e1 = 1'b0;
    for (int i = 0; i < N; i++) begin
      clk_ok[i] = (loss_r[i] < ltic_pkg::LOSS_LIMIT);
      if (host_mode && !pin_ctl) begin
        oe_eff[i] = ch_reg_r[i][ltic_pkg::CH_TX_ON_BIT];
      end else begin
        oe_eff[i] = pin_s2_r.tx_on[i];
      end
      if (host_mode) begin
        aos_eff[i] = ch_reg_r[i][ltic_pkg::CH_ALL_ONES_BIT];
        dual_sel[i] = ch_reg_r[i][ltic_pkg::CH_DUAL_BIT];
        ami = ch_reg_r[i][ltic_pkg::CH_AMI_BIT];
        e1 = ch_reg_r[i][ltic_pkg::CH_E1_BIT];
      end else begin
        aos_eff[i] = pin_s2_r.all_ones[i];
        dual_sel[i] = pin_s2_r.dual_rail;
        ami = rx_r[i].neg;
        e1 = pin_s2_r.rate_e1;
      end
      if (ami) begin
        code_sel[i] = ltic_pkg::LTIC_CODE_AMI;
      end else if (e1) begin
        code_sel[i] = ltic_pkg::LTIC_CODE_HDB3;
      end else begin
        code_sel[i] = ltic_pkg::LTIC_CODE_B8ZS;
      end
    end
  end

  // ***************************************************************
  // Channel datapath next state
  // ***************************************************************
  always_comb begin
    ltic_pkg::ltic_step_t st;
    logic p;
    st = '0;
    p = 1'b0;
    rx_nxt = rx_r;
    loss_nxt = loss_r;
    dly_nxt = dly_r;
    par_nxt = par_r;
    last_nxt = last_r;
    pos_nxt = pos_r;
    neg_nxt = neg_r;
    oe_nxt = oe_eff;
    for (int i = 0; i < N; i++) begin
      if (strobe[i]) begin
        rx_nxt[i] = link_rails[i];
        loss_nxt[i] = '0;
      end else if (loss_r[i] < ltic_pkg::LOSS_LIMIT) begin
        loss_nxt[i] = loss_r[i] + ltic_pkg::LOSS_ONE;
      end
    end
    for (int i = 0; i < N; i++) begin
      if (rx_nxt[i] != rx_r[i] || strobe[i]) begin
        p = 1'b0;
      end
      if (strobe[i]) begin
        st = ltic_code_step(dly_r[i], par_r[i], aos_eff[i] | link_rails[i].pos, code_sel[i]);
        dly_nxt[i] = st.dly;
        par_nxt[i] = st.par;
        p = ltic_sym_pol(st.sym, last_r[i]);
        if (st.sym != ltic_pkg::SYM_ZERO) begin
          last_nxt[i] = p;
        end
        if (dual_sel[i] && !aos_eff[i]) begin
          pos_nxt[i] = link_rails[i].pos;
          neg_nxt[i] = link_rails[i].neg;
        end else begin
          pos_nxt[i] = (st.sym != ltic_pkg::SYM_ZERO) && p;
          neg_nxt[i] = (st.sym != ltic_pkg::SYM_ZERO) && !p;
        end
      end
      if (!clk_ok[i] || !oe_eff[i]) begin
        pos_nxt[i] = 1'b0;
        neg_nxt[i] = 1'b0;
      end
    end
  end

  // ***************************************************************
  // Register port next state
  // ***************************************************************
  always_comb begin
    ch_reg_nxt = ch_reg_r;
    global_nxt = global_r;
    rdata_nxt = ltic_pkg::RDATA_IDLE;
    if (reg_wr_in) begin
      if (reg_addr_in <= ltic_pkg::ADDR_CH_LAST) begin
        ch_reg_nxt[reg_addr_in[2:0]] = reg_wdata_in & ltic_pkg::CH_REG_MASK;
      end else if (reg_addr_in == ltic_pkg::ADDR_GLOBAL) begin
        global_nxt = reg_wdata_in & ltic_pkg::GLOBAL_MASK;
      end
    end
    if (reg_rd_in) begin
      if (reg_addr_in <= ltic_pkg::ADDR_CH_LAST) begin
        rdata_nxt = ch_reg_r[reg_addr_in[2:0]];
      end else begin
        case (reg_addr_in)
          ltic_pkg::ADDR_GLOBAL: rdata_nxt = global_r;
          ltic_pkg::ADDR_CLK_STAT: rdata_nxt = clk_ok;
          ltic_pkg::ADDR_OE_STAT: rdata_nxt = oe_r;
          ltic_pkg::ADDR_MODE_STAT: begin
            rdata_nxt[ltic_pkg::MS_HOST_BIT] = host_mode;
            rdata_nxt[ltic_pkg::MS_BUS_LO_BIT] = bus_type_r[0];
            rdata_nxt[ltic_pkg::MS_BUS_HI_BIT] = bus_type_r[1];
          end
          default: rdata_nxt = ltic_pkg::RDATA_IDLE;
        endcase
      end
    end
    if (host_mode) begin
      bus_type_nxt = {pin_s2_r.edge_sel, pin_s2_r.bus_lo};
    end else begin
      bus_type_nxt = ltic_pkg::BUS_TYPE_NONE;
    end
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      tgl_s1_r <= '0;
      tgl_s2_r <= '0;
      tgl_s3_r <= '0;
      rx_r <= '0;
      loss_r <= {N{ltic_pkg::LOSS_LIMIT}};
      dly_r <= {N{ltic_pkg::DLY_RST}};
      par_r <= '0;
      last_r <= '0;
      ch_reg_r <= {N{ltic_pkg::CH_REG_RST}};
      global_r <= ltic_pkg::GLOBAL_RST;
      rdata_r <= ltic_pkg::RDATA_IDLE;
      pos_r <= '0;
      neg_r <= '0;
      oe_r <= '0;
      bus_type_r <= ltic_pkg::BUS_TYPE_NONE;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      tgl_s1_r <= link_tgl;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
      rx_r <= rx_nxt;
      loss_r <= loss_nxt;
      dly_r <= dly_nxt;
      par_r <= par_nxt;
      last_r <= last_nxt;
      ch_reg_r <= ch_reg_nxt;
      global_r <= global_nxt;
      rdata_r <= rdata_nxt;
      pos_r <= pos_nxt;
      neg_r <= neg_nxt;
      oe_r <= oe_nxt;
      bus_type_r <= bus_type_nxt;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign reg_rdata_out = rdata_r;
  assign tx_line_pos_out = pos_r;
  assign tx_line_neg_out = neg_r;
  assign tx_line_oe_out = oe_r;
  assign host_bus_type_sel_out = bus_type_r;

endmodule // ltic_tx_input_ctrl

`default_nettype wire

// ==== pkg/ltic_pkg.sv ====
// Constants and types shared by the transmit input control block
package ltic_pkg;

  // ***************************************************************
  // Sizes
  // ***************************************************************
  localparam int NUM_CH = 8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int SYM_W = 2;
  localparam int DLY_LEN = 8;
  localparam int DLY_W = SYM_W * DLY_LEN;
  localparam int HDB3_LEN = 4;
  localparam int HDB3_W = SYM_W * HDB3_LEN;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [ADDR_W-1:0] ADDR_CH_LAST = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_GLOBAL = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_CLK_STAT = 4'h9;
  localparam logic [ADDR_W-1:0] ADDR_OE_STAT = 4'ha;
  localparam logic [ADDR_W-1:0] ADDR_MODE_STAT = 4'hb;
  localparam logic [DATA_W-1:0] CH_REG_RST = 8'h00;
  localparam logic [DATA_W-1:0] GLOBAL_RST = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;
  // Channel register fields
  localparam int CH_TX_ON_BIT = 0;
  localparam int CH_ALL_ONES_BIT = 1;
  localparam int CH_AMI_BIT = 2;
  localparam int CH_DUAL_BIT = 3;
  localparam int CH_E1_BIT = 4;
  localparam logic [DATA_W-1:0] CH_REG_MASK = 8'h1f;
  // Global register fields
  localparam int GL_PIN_CTL_BIT = 0;
  localparam logic [DATA_W-1:0] GLOBAL_MASK = 8'h01;
  // Mode status fields
  localparam int MS_HOST_BIT = 0;
  localparam int MS_BUS_LO_BIT = 1;
  localparam int MS_BUS_HI_BIT = 2;

  // ***************************************************************
  // Line code symbols
  // ***************************************************************
  localparam logic [SYM_W-1:0] SYM_ZERO = 2'h0;
  localparam logic [SYM_W-1:0] SYM_MARK = 2'h1;
  localparam logic [SYM_W-1:0] SYM_VIOL = 2'h2;
  localparam logic [SYM_W-1:0] SYM_BIPV = 2'h3;
  localparam logic [DLY_W-1:0] DLY_RST = 16'h0000;
  localparam logic [DLY_W-1:0] B8ZS_SUBST = {SYM_ZERO, SYM_ZERO, SYM_ZERO, SYM_VIOL,
                                             SYM_BIPV, SYM_ZERO, SYM_VIOL, SYM_BIPV};
  localparam logic [HDB3_W-1:0] HDB3_ODD = {SYM_ZERO, SYM_ZERO, SYM_ZERO, SYM_VIOL};
  localparam logic [HDB3_W-1:0] HDB3_EVEN = {SYM_BIPV, SYM_ZERO, SYM_ZERO, SYM_VIOL};

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int REF_PERIOD_NS = 50;
  localparam int LOSS_TIME_NS = 4000;
  localparam int LOSS_CYCLES = (LOSS_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int LOSS_W = 7;
  localparam logic [LOSS_W-1:0] LOSS_LIMIT = LOSS_W'(LOSS_CYCLES);
  localparam logic [LOSS_W-1:0] LOSS_ONE = 7'h01;

  // ***************************************************************
  // Host bus type codes
  // ***************************************************************
  localparam logic [1:0] BUS_TYPE_ASYNC_A = 2'h0;
  localparam logic [1:0] BUS_TYPE_ASYNC_B = 2'h1;
  localparam logic [1:0] BUS_TYPE_NONE = 2'h0;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [2:0] {
    LTIC_CODE_AMI = 3'b001,
    LTIC_CODE_B8ZS = 3'b010,
    LTIC_CODE_HDB3 = 3'b100
  } ltic_code_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } ltic_rails_t;

  typedef struct packed {
    logic edge_sel;
    logic mode_hw;
    logic bus_lo;
    logic dual_rail;
    logic rate_e1;
    logic [NUM_CH-1:0] all_ones;
    logic [NUM_CH-1:0] tx_on;
  } ltic_pins_t;

  typedef struct packed {
    logic [DLY_W-1:0] dly;
    logic par;
    logic [SYM_W-1:0] sym;
  } ltic_step_t;

endpackage
